// >>> pmrb_bank.v
// management register bank for the two embedded phys
//
// What this block does
// - answer phy addresses 0x1 and 0x2
// - only registers 0-5, 0x1D, 0x1F exist
// - same registers reachable by host port
// - speed bit forces 100 or 10 Mbps
// - bit 12 enables auto-negotiation, resets one
// - bit 11 powers the phy down
// - bit 9 write restarts auto-negotiation
// - bit 8 duplex when forced; half on failure
// - bit 5 picks crossover variant, resets one
// - bit 4 forces crossed pair assignment
// - bit 3 disables automatic crossover
// - bit 2 disables far-end fault detection
// - bit 1 disables transmit, bit 0 LED
// - far-end loopback loops port 2 at port 1
// - isolate and collision test read zero
// - regulator off bit, resets zero
// - diagnostic enable self-clears on completion
`include "pmrb_map.vh"

module pmrb_bank (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // management frame side, already deframed
    input wire mg_req,
    input wire mg_wr,
    input wire [4:0] mg_phy,
    input wire [4:0] mg_reg,
    input wire [15:0] mg_wdata,
    output reg [15:0] mg_rdata,
    output reg mg_ack,
    output reg mg_hit,
    // host port side
    input wire hp_req,
    input wire hp_wr,
    input wire [10:0] hp_addr,
    input wire [15:0] hp_wdata,
    output reg [15:0] hp_rdata,
    output reg hp_ack,
    // phy status inputs, index 0 = port 1
    input wire [1:0] an_done,
    input wire [1:0] an_ok,
    input wire [1:0] link_up,
    input wire [1:0] far_fault,
    input wire [1:0] diag_done,
    input wire [3:0] diag_result,
    input wire [15:0] partner_ability,
    input wire [15:0] special_status,
    // controls to the phys
    output reg [1:0] speed_100,
    output reg [1:0] full_duplex,
    output reg [1:0] an_enable,
    output reg [1:0] power_down,
    output reg [1:0] an_restart,
    output reg [1:0] crossover_variant_select,
    output reg [1:0] force_mdix,
    output reg [1:0] auto_mdix_off,
    output reg [1:0] fef_off,
    output reg [1:0] tx_off,
    output reg [1:0] led_off,
    output reg far_end_loopback,
    output reg [1:0] cable_diagnostic_start,
    output reg internal_regulator_off,
    output reg pulse_mask_bit,
    output reg receive_reduce_bit
);

    // arbitrary neutral identity values
    parameter [15:0] ID_HI = 16'h0_000;
    parameter [15:0] ID_LO = 16'h0_001;

    // ==============================================
    // reset release
    reg rst_s1_r;
    reg rst_s2_r;
    wire rst_sn = rst_s2_r;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // ==============================================
    // storage
    reg [15:0] bc_r [0:1];
    reg [15:0] adv_r [0:1];
    reg [1:0] diag_en_r;
    reg [15:0] regctl_r;
    reg [15:0] prep_r;

    // which phy a management address selects, 2 = none
    function [1:0] phy_sel;
        input [4:0] pa;
        begin
            if (pa == `PMRB_PHY1_ADDR)
                phy_sel = 2'd0;
            else if (pa == `PMRB_PHY2_ADDR)
                phy_sel = 2'd1;
            else
                phy_sel = 2'd2;
        end
    endfunction

    // register implemented at this address
    function reg_ok;
        input [4:0] ra;
        begin
            reg_ok = (ra <= `PMRB_REG_PARTNER) || (ra == `PMRB_REG_DIAG) ||
                     (ra == `PMRB_REG_SPECIAL);
        end
    endfunction

    // read value of one phy register
    function [15:0] phy_read;
        input p;
        input [4:0] ra;
        reg [15:0] st;
        begin
            st = `PMRB_STAT_CONST;
            st[5] = an_done[p];
            st[4] = far_fault[p];
            st[2] = link_up[p];
            case (ra)
                `PMRB_REG_BASIC_CTRL: phy_read = bc_r[p];
                `PMRB_REG_BASIC_STAT: phy_read = st;
                `PMRB_REG_ID_HI: phy_read = ID_HI;
                `PMRB_REG_ID_LO: phy_read = ID_LO;
                `PMRB_REG_ADV: phy_read = adv_r[p];
                `PMRB_REG_PARTNER: phy_read = partner_ability;
                `PMRB_REG_DIAG: phy_read = {diag_en_r[p], diag_result[2*p+1], diag_result[2*p], 13'h0_000};
                `PMRB_REG_SPECIAL: phy_read = special_status;
                default: phy_read = `PMRB_ZERO16;
            endcase
        end
    endfunction

    // host port view: each phy occupies a 32-byte window, register n at base + 2n;
    // the last two slots carry the diagnostic and special registers so both stay reachable
    wire hp_p1 = (hp_addr[10:5] == `PMRB_HOST_P1_BASE >> 5);
    wire hp_p2 = (hp_addr[10:5] == `PMRB_HOST_P2_BASE >> 5);
    wire [4:0] hp_reg = {1'b0, hp_addr[4:1]} +
                        ((hp_addr[4:1] == 4'hE) ? 5'h0F : (hp_addr[4:1] == 4'hF) ? 5'h10 : 5'h00);

    // ==============================================
    // unified write port; management wins when both hit
    wire [1:0] mg_p = phy_sel(mg_phy);
    reg w_en;
    reg w_p;
    reg [4:0] w_ra;
    reg [15:0] w_d;

    always @*
    begin
        w_en = 1'b0;
        w_p = 1'b0;
        w_ra = mg_reg;
        w_d = mg_wdata;
        if (mg_req && mg_wr && mg_p != 2'd2 && reg_ok(mg_reg))
        begin
            w_en = 1'b1;
            w_p = mg_p[0];
        end
        else if (hp_req && hp_wr && (hp_p1 || hp_p2))
        begin
            w_en = 1'b1;
            w_p = hp_p2;
            w_ra = hp_reg;
            w_d = hp_wdata;
        end
    end

    // ==============================================
    // per-phy registers
    integer i;
    always @(posedge clk or negedge rst_sn)
    begin
        if (!rst_sn)
        begin
            for (i = 0; i < 2; i = i + 1)
            begin
                bc_r[i] <= `PMRB_BC_RST;
                adv_r[i] <= `PMRB_ADV_RST;
            end
            diag_en_r <= 2'b00;
        end
        else
        begin
            for (i = 0; i < 2; i = i + 1)
            begin
                // restart is a pulse: the bit drops back after one cycle
                bc_r[i][`PMRB_BC_AN_RESTART] <= 1'b0;
                // completion wins over a simultaneous write of the enable
                if (w_en && w_p == i && w_ra == `PMRB_REG_DIAG && !diag_done[i])
                    diag_en_r[i] <= w_d[`PMRB_DIAG_EN_BIT];
                else if (diag_done[i])
                    diag_en_r[i] <= 1'b0;
                if (w_en && w_p == i && w_ra == `PMRB_REG_BASIC_CTRL)
                    bc_r[i] <= w_d & `PMRB_BC_WMASK;
                if (w_en && w_p == i && w_ra == `PMRB_REG_ADV)
                    adv_r[i] <= (w_d & `PMRB_ADV_WMASK) | (`PMRB_ADV_RST & ~`PMRB_ADV_WMASK);
            end
        end
    end

    // ==============================================
    // analog control registers, host port only
    always @(posedge clk or negedge rst_sn)
    begin
        if (!rst_sn)
        begin
            regctl_r <= `PMRB_ZERO16;
            prep_r <= `PMRB_ZERO16;
        end
        else if (hp_req && hp_wr)
        begin
            if (hp_addr == `PMRB_HOST_REGULATOR)
                regctl_r <= hp_wdata;
            if (hp_addr == `PMRB_HOST_CABLE_PREP)
                prep_r <= hp_wdata;
        end
    end

    // ==============================================
    // read answers, one cycle after the request
    always @(posedge clk or negedge rst_sn)
    begin
        if (!rst_sn)
        begin
            mg_rdata <= `PMRB_ZERO16;
            mg_ack <= 1'b0;
            mg_hit <= 1'b0;
            hp_rdata <= `PMRB_ZERO16;
            hp_ack <= 1'b0;
        end
        else
        begin
            mg_ack <= mg_req;
            hp_ack <= hp_req;
            if (mg_req)
            begin
                mg_hit <= (mg_p != 2'd2);
                mg_rdata <= (mg_p == 2'd2) ? `PMRB_ZERO16 : phy_read(mg_p[0], mg_reg);
            end
            if (hp_req)
            begin
                if (hp_p1 || hp_p2)
                    hp_rdata <= phy_read(hp_p2, hp_reg);
                else if (hp_addr == `PMRB_HOST_REGULATOR)
                    hp_rdata <= regctl_r;
                else if (hp_addr == `PMRB_HOST_CABLE_PREP)
                    hp_rdata <= prep_r;
                else
                    hp_rdata <= `PMRB_ZERO16;
            end
        end
    end

    // ==============================================
    // control outputs from flops
    integer k;
    always @(posedge clk or negedge rst_sn)
    begin
        if (!rst_sn)
        begin
            speed_100 <= 2'b00;
            full_duplex <= 2'b00;
            an_enable <= 2'b11;
            power_down <= 2'b00;
            an_restart <= 2'b00;
            crossover_variant_select <= 2'b11;
            force_mdix <= 2'b00;
            auto_mdix_off <= 2'b00;
            fef_off <= 2'b00;
            tx_off <= 2'b00;
            led_off <= 2'b00;
            far_end_loopback <= 1'b0;
            cable_diagnostic_start <= 2'b00;
            internal_regulator_off <= 1'b0;
            pulse_mask_bit <= 1'b0;
            receive_reduce_bit <= 1'b0;
        end
        else
        begin
            for (k = 0; k < 2; k = k + 1)
            begin
                an_enable[k] <= bc_r[k][`PMRB_BC_AN_EN];
                speed_100[k] <= bc_r[k][`PMRB_BC_SPEED] & ~bc_r[k][`PMRB_BC_AN_EN];
                full_duplex[k] <= bc_r[k][`PMRB_BC_AN_EN] ? an_ok[k] : bc_r[k][`PMRB_BC_DUPLEX];
                power_down[k] <= bc_r[k][`PMRB_BC_PWRDN];
                an_restart[k] <= bc_r[k][`PMRB_BC_AN_RESTART];
                crossover_variant_select[k] <= bc_r[k][`PMRB_BC_XVAR];
                force_mdix[k] <= bc_r[k][`PMRB_BC_FORCE_MDIX];
                auto_mdix_off[k] <= bc_r[k][`PMRB_BC_NO_AUTOX];
                fef_off[k] <= bc_r[k][`PMRB_BC_NO_FEF];
                tx_off[k] <= bc_r[k][`PMRB_BC_NO_TX];
                led_off[k] <= bc_r[k][`PMRB_BC_NO_LED];
                cable_diagnostic_start[k] <= diag_en_r[k];
            end
            // loopback sits in port 1's phy and serves port 2's pairs
            far_end_loopback <= bc_r[0][`PMRB_BC_LOOPBACK];
            internal_regulator_off <= regctl_r[`PMRB_REG_OFF_BIT];
            pulse_mask_bit <= prep_r[`PMRB_PULSE_MASK_BIT];
            receive_reduce_bit <= prep_r[`PMRB_RX_REDUCE_BIT];
        end
    end

endmodule

// >>> pmrb_map.vh
// address map, field positions and reset values of the phy management register bank
`ifndef PMRB_MAP_VH
`define PMRB_MAP_VH

// ==============================================
// management addressing
`define PMRB_PHY1_ADDR 5'h01
`define PMRB_PHY2_ADDR 5'h02
`define PMRB_REG_BASIC_CTRL 5'h00
`define PMRB_REG_BASIC_STAT 5'h01
`define PMRB_REG_ID_HI 5'h02
`define PMRB_REG_ID_LO 5'h03
`define PMRB_REG_ADV 5'h04
`define PMRB_REG_PARTNER 5'h05
`define PMRB_REG_DIAG 5'h1D
`define PMRB_REG_SPECIAL 5'h1F

// ==============================================
// host port byte addresses
`define PMRB_HOST_P1_BASE 11'h0_4C0
`define PMRB_HOST_P2_BASE 11'h0_4E0
`define PMRB_HOST_REGULATOR 11'h0_748
`define PMRB_HOST_CABLE_PREP 11'h0_74C

// ==============================================
// basic control fields
`define PMRB_BC_LOOPBACK 14
`define PMRB_BC_SPEED 13
`define PMRB_BC_AN_EN 12
`define PMRB_BC_PWRDN 11
`define PMRB_BC_ISOLATE 10
`define PMRB_BC_AN_RESTART 9
`define PMRB_BC_DUPLEX 8
`define PMRB_BC_COLTEST 7
`define PMRB_BC_XVAR 5
`define PMRB_BC_FORCE_MDIX 4
`define PMRB_BC_NO_AUTOX 3
`define PMRB_BC_NO_FEF 2
`define PMRB_BC_NO_TX 1
`define PMRB_BC_NO_LED 0
`define PMRB_BC_RST 16'h1_020
`define PMRB_BC_WMASK 16'h7_B3F

// ==============================================
// other fields and constant registers
`define PMRB_REG_OFF_BIT 7
`define PMRB_PULSE_MASK_BIT 15
`define PMRB_RX_REDUCE_BIT 3
`define PMRB_DIAG_EN_BIT 15
`define PMRB_STAT_CONST 16'h7_808
`define PMRB_ADV_RST 16'h0_5E1
`define PMRB_ADV_WMASK 16'h0_5E0
`define PMRB_ZERO16 16'h0_000

`endif

// >>> pmrb_bank_props.sv
// assertion checker for the phy management register bank ports
module pmrb_bank_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // management side
    input wire logic mg_req,
    input wire logic mg_wr,
    input wire logic [4:0] mg_phy,
    input wire logic [4:0] mg_reg,
    input wire logic [15:0] mg_wdata,
    input wire logic [15:0] mg_rdata,
    input wire logic mg_ack,
    input wire logic mg_hit,
    // phy controls and status
    input wire logic [1:0] speed_100,
    input wire logic [1:0] an_enable,
    input wire logic [1:0] an_restart,
    input wire logic [1:0] diag_done,
    input wire logic [1:0] cable_diagnostic_start
);
    // ====
    // properties
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    wire bc1 = mg_req && mg_wr && mg_phy == 5'h01 && mg_reg == 5'h00;

    AST_MG_ACK: assert property (mg_req |=> mg_ack) else $error("ack missing");
    AST_ACK_CAUSE: assert property (mg_ack |-> $past(mg_req)) else $error("stray ack");
    AST_HIT: assert property (mg_req |=> mg_hit == ($past(mg_phy) inside {5'h01, 5'h02})) else $error("hit");
    AST_UNSUP: assert property (mg_req && !mg_wr && mg_reg inside {[5'h06:5'h1C], 5'h1E} |=> mg_rdata == '0)
        else $error("unsupported read");
    // a second restart write right behind the first legally stretches the pulse
    AST_RESTART_PULSE: assert property (an_restart[0] && !$past(bc1 && mg_wdata[9]) |=> !an_restart[0])
        else $error("restart held");
    // register lands one edge after the request, the control output one edge later
    AST_RESTART_CAUSE: assert property (bc1 && mg_wdata[9] |-> ##2 an_restart[0]) else $error("no restart");
    AST_FORCE: assert property (bc1 && !mg_wdata[12] |-> ##2 (!an_enable[0] && speed_100[0] == $past(mg_wdata[13], 2)))
        else $error("forced speed");
    AST_DIAG_CLR: assert property (diag_done[0] |-> ##2 !cable_diagnostic_start[0]) else $error("diag stuck");
    cover property (bc1 && mg_wdata[9] ##2 an_restart[0]);
    cover property (diag_done[0] && cable_diagnostic_start[0]);
    cover property (mg_req && !mg_wr ##1 mg_hit);
endmodule

bind pmrb_bank pmrb_bank_props u_props (.*);

// >>> pmrb_station.sv
// management station and host port model issuing one access at a time
module pmrb_station (
    input wire logic clk,
    // management side
    output logic mg_req,
    output logic mg_wr,
    output logic [4:0] mg_phy,
    output logic [4:0] mg_reg,
    output logic [15:0] mg_wdata,
    input wire logic [15:0] mg_rdata,
    input wire logic mg_ack,
    // host side
    output logic hp_req,
    output logic hp_wr,
    output logic [10:0] hp_addr,
    output logic [15:0] hp_wdata,
    input wire logic [15:0] hp_rdata,
    input wire logic hp_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {mg_req, mg_wr, mg_phy, mg_reg, mg_wdata, hp_req, hp_wr, hp_addr, hp_wdata} = '0;
    end
    // ====
    // one access; a 16-bit word per request, request is a one-cycle pulse
    task automatic xfer(input logic h, input logic w, input logic [10:0] a, input logic [15:0] d,
        output logic [15:0] q, output logic ok);
        ok = 1'b0;
        @(posedge clk);
        #1;
        if (h)
            {hp_req, hp_wr, hp_addr, hp_wdata} = {1'b1, w, a, d};
        else
            {mg_req, mg_wr, mg_phy, mg_reg, mg_wdata} = {1'b1, w, a[9:0], d};
        @(posedge clk);
        #1;
        // released fields show the inverse so a late capture cannot pass
        {hp_req, mg_req} = 2'h0;
        {hp_wr, hp_addr, hp_wdata, mg_wr, mg_phy, mg_reg, mg_wdata} = ~{w, a, d, w, a[9:0], d};
        for (int n = 0; n < 4 && !ok; n++)
        begin
            @(posedge clk);
            ok = (h ? hp_ack : mg_ack) === 1'b1;
        end
        q = h ? hp_rdata : mg_rdata;
        #1;
    endtask
endmodule

// >>> pmrb_bank_test.sv
// self-checking testbench for the phy management register bank
`include "pmrb_map.vh"
module pmrb_bank_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ====
    // signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic mg_req, mg_wr, mg_ack, mg_hit, hp_req, hp_wr, hp_ack, far_end_loopback;
    logic internal_regulator_off, pulse_mask_bit, receive_reduce_bit;
    logic [4:0] mg_phy, mg_reg;
    logic [10:0] hp_addr;
    logic [15:0] mg_wdata, mg_rdata, hp_wdata, hp_rdata, q;
    logic [1:0] an_done = '0, an_ok = '0, link_up = '0, far_fault = '0, diag_done = '0;
    logic [3:0] diag_result = '0;
    logic [15:0] partner_ability = '0, special_status = '0;
    logic [1:0] speed_100, full_duplex, an_enable, power_down, an_restart, crossover_variant_select;
    logic [1:0] force_mdix, auto_mdix_off, fef_off, tx_off, led_off, cable_diagnostic_start;
    int bad_count = 0;
    int n_compared = 0;
    // port 1 controls laid out like its basic control word
    wire [15:0] ctl0 = {1'b0, far_end_loopback, speed_100[0], an_enable[0], power_down[0], 1'b0, an_restart[0],
        full_duplex[0], 2'h0, crossover_variant_select[0], force_mdix[0], auto_mdix_off[0], fef_off[0],
        tx_off[0], led_off[0]};

    pmrb_bank dut (.*);
    pmrb_station st (.*);

    initial
    begin
        forever #5 clk = ~clk;
    end

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic acc(input logic h, input logic w, input logic [10:0] a, input logic [15:0] d, input logic [15:0] e);
        logic ok;
        st.xfer(h, w, a, d, q, ok);
        if (!ok)
        begin
            bad_count++;
            $display("ERROR %0t: no acknowledge", $time);
            results();
        end
        if (!w)
            chk(q, e);
    endtask

    // write port 1 basic control, read it back, then check the control outputs
    task automatic bc(input logic [15:0] v);
        logic [15:0] e;
        e = v & `PMRB_BC_WMASK & ~16'h0_200;
        acc(0, 1, 11'h0_020, v, '0);
        acc(0, 0, 11'h0_020, '0, e);
        if (e[12])
        begin
            e[13] = 1'b0;
            e[8] = an_ok[0];
        end
        chk(ctl0, e);
    endtask

    // ====
    // main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk(ctl0, 16'h1_020);
        repeat (3) @(posedge clk);
        for (int p = 1; p <= 2; p++)
        begin
            acc(0, 0, {1'b0, p[4:0], 5'h00}, '0, 16'h1_020);
            chk(mg_hit, 1'b1);
        end
        for (int p = 0; p < 4; p += 3)
        begin
            acc(0, 1, {1'b0, p[4:0], 5'h00}, '0, '0);
            acc(0, 0, {1'b0, p[4:0], 5'h00}, '0, '0);
            chk(mg_hit, 1'b0);
        end
        acc(0, 0, 11'h0_020, '0, 16'h1_020);
        for (int r = 6; r < 32; r += (r == 28) ? 2 : 11)
        begin
            acc(0, 1, {6'h01, r[4:0]}, 16'hF_FFF, '0);
            acc(0, 0, {6'h01, r[4:0]}, '0, '0);
        end
        {an_done, far_fault, link_up} = 6'h15;
        acc(0, 0, 11'h0_021, '0, 16'h7_83C);
        bc(16'hF_FFF);
        an_ok = 2'h1;
        bc(16'h1_100);
        bc(16'h2_13F);
        bc(16'h4_000);
        bc(16'h1_200);
        acc(1, 0, `PMRB_HOST_REGULATOR, '0, '0);
        acc(1, 1, `PMRB_HOST_REGULATOR, 16'h0_080, '0);
        acc(1, 0, `PMRB_HOST_REGULATOR, '0, 16'h0_080);
        chk(internal_regulator_off, 1'b1);
        acc(1, 1, `PMRB_HOST_CABLE_PREP, 16'h8_008, '0);
        chk({pulse_mask_bit, receive_reduce_bit}, 2'h3);
        acc(1, 0, `PMRB_HOST_CABLE_PREP, '0, 16'h8_008);
        acc(1, 0, `PMRB_HOST_P2_BASE, '0, 16'h1_020);
        acc(1, 0, `PMRB_HOST_P1_BASE, '0, 16'h1_000);
        // a host write must land in the same register the management side reads
        acc(1, 1, `PMRB_HOST_P2_BASE, 16'h0_800, '0);
        acc(0, 0, 11'h0_040, '0, 16'h0_800);
        chk(power_down, 2'h2);
        special_status = 16'hA_5C3;
        acc(1, 0, `PMRB_HOST_P1_BASE + 11'h0_01E, '0, 16'hA_5C3);
        acc(0, 1, 11'h0_03D, 16'h8_000, '0);
        chk(cable_diagnostic_start[0], 1'b1);
        diag_result = 4'h2;
        diag_done = 2'h1;
        @(posedge clk);
        #1;
        diag_done = 2'h0;
        // the enable clears on the done edge, the start output one edge later
        @(posedge clk);
        #1;
        chk(cable_diagnostic_start[0], 1'b0);
        acc(0, 0, 11'h0_03D, '0, 16'h4_000);
        results();
    end
endmodule
